// [rtl/codec_cfg_pkg.sv]
// Constants for the codec power and clock configuration registers
`default_nettype none
package codec_cfg_pkg;

    // ------------------------------------------------------------
    // Register offsets, widths
    // ------------------------------------------------------------
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 16;
    localparam logic [7:0] OFF_IDENTITY = 8'h00;
    localparam logic [7:0] OFF_POWER    = 8'h02;
    localparam logic [7:0] OFF_CLOCK    = 8'h04;
    localparam logic [7:0] OFF_FORMAT   = 8'h06;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_ADC_EN   = 6;
    localparam int POS_DAC_EN   = 5;
    localparam int POS_PROC_EN  = 4;
    localparam int POS_OUT_EN   = 1;
    localparam int POS_IN_EN    = 0;
    localparam int POWER_MSB    = 6;
    localparam int POS_DIVIDER  = 4;
    localparam int POS_SYSRATE  = 2;
    localparam int POS_RATIO    = 0;
    localparam int CLOCK_MSB    = 5;
    localparam int FORMAT_MSB   = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] RST_POWER  = 7'h00;
    localparam logic [5:0] RST_CLOCK  = 6'h08;
    localparam logic [8:0] RST_FORMAT = 9'h010;
    localparam logic [1:0] SYSRATE_RST = 2'h2;

    // ------------------------------------------------------------
    // Clock codes and rate figures in Hz
    // ------------------------------------------------------------
    localparam logic [1:0] RATIO_PLL  = 2'h3;
    localparam logic [16:0] HZ_32K  = 17'h0_7D00;
    localparam logic [16:0] HZ_44K1 = 17'h0_AC44;
    localparam logic [16:0] HZ_48K  = 17'h0_BB80;
    localparam logic [16:0] HZ_96K  = 17'h1_7700;
    localparam logic [2:0]  DIV_1 = 3'h1;
    localparam logic [2:0]  DIV_2 = 3'h2;
    localparam logic [2:0]  DIV_4 = 3'h4;
    localparam logic [2:0]  DIV_6 = 3'h6;
    localparam logic [9:0]  MUL_256 = 10'h100;
    localparam logic [9:0]  MUL_384 = 10'h180;
    localparam logic [9:0]  MUL_512 = 10'h200;

endpackage

`default_nettype wire

// [rtl/codec_power_clock_config.sv]
// Power enable and clock setup register bank of the stereo codec
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module codec_power_clock_config #(
    parameter logic [7:0] PART_ID  = 8'h5C,  // Arbitrary value
    parameter logic [7:0] REVISION = 8'h00   // Arbitrary value
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [7:0]   regAddr,
    input  wire logic [15:0]  writeData,
    input  wire logic         writeStrobe,
    input  wire logic         readStrobe,
    output logic      [15:0]  readData,
    output logic              adcPowerEnable,
    output logic              dacPowerEnable,
    output logic              audioProcessorPowerEnable,
    output logic              serialAudioOutEnable,
    output logic              serialAudioInEnable,
    output logic      [1:0]   systemSampleRate,
    output logic      [1:0]   rateDivider,
    output logic      [1:0]   masterClockRatio,
    output logic              pllClockSelect,
    output logic      [8:0]   serialFormat,
    output logic      [16:0]  workingRateHz,
    output logic      [26:0]  masterClockHz
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [6:0]   power_q;
    logic [5:0]   clock_q;
    logic [8:0]   format_q;
    logic [15:0]  readData_q;
    logic [15:0]  readData_d;
    logic [16:0]  workingRate_q;
    logic [16:0]  workingRate_d;
    logic [26:0]  mclkHz_q;
    logic [26:0]  mclkHz_d;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire          hitIdentity;
    wire          hitPower;
    wire          hitClock;
    wire          hitFormat;
    wire          writePower;
    wire          writeClock;
    wire          writeFormat;

    // One select per register
    assign hitIdentity = (regAddr == codec_cfg_pkg::OFF_IDENTITY);
    assign hitPower    = (regAddr == codec_cfg_pkg::OFF_POWER);
    assign hitClock    = (regAddr == codec_cfg_pkg::OFF_CLOCK);
    assign hitFormat   = (regAddr == codec_cfg_pkg::OFF_FORMAT);
    assign writePower  = writeStrobe && hitPower;
    assign writeClock  = writeStrobe && hitClock;
    assign writeFormat = writeStrobe && hitFormat;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Power bits, reserved 3:2 kept as written
    always_ff @(posedge clk) begin
        if (rst) begin
            power_q <= codec_cfg_pkg::RST_POWER;
        end else if (writePower) begin
            power_q <= writeData[codec_cfg_pkg::POWER_MSB:0];
        end
    end

    // Clock setup bits, 15:6 not stored
    always_ff @(posedge clk) begin
        if (rst) begin
            clock_q <= codec_cfg_pkg::RST_CLOCK;
        end else if (writeClock) begin
            clock_q <= writeData[codec_cfg_pkg::CLOCK_MSB:0];
        end
    end

    // Serial format bits, 15:9 not stored
    always_ff @(posedge clk) begin
        if (rst) begin
            format_q <= codec_cfg_pkg::RST_FORMAT;
        end else if (writeFormat) begin
            format_q <= writeData[codec_cfg_pkg::FORMAT_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [15:0]   idWord;
    wire [15:0]   powerWord;
    wire [15:0]   clockWord;
    wire [15:0]   formatWord;

    // Read-only reserved bits padded with zero
    assign idWord     = {PART_ID, REVISION};
    assign powerWord  = {9'h000, power_q};
    assign clockWord  = {10'h000, clock_q};
    assign formatWord = {7'h00, format_q};

    // Read mux, unmapped offsets answer zero
    assign readData_d = !readStrobe ? 16'h0000 :
                        hitIdentity ? idWord :
                        hitPower    ? powerWord :
                        hitClock    ? clockWord :
                        hitFormat   ? formatWord : 16'h0000;

    // Answer stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            readData_q <= 16'h0000;
        end else begin
            readData_q <= readData_d;
        end
    end

    assign readData = readData_q;

    // ------------------------------------------------------------
    // Power enables
    // ------------------------------------------------------------
    assign adcPowerEnable            = power_q[codec_cfg_pkg::POS_ADC_EN];
    assign dacPowerEnable            = power_q[codec_cfg_pkg::POS_DAC_EN];
    assign audioProcessorPowerEnable = power_q[codec_cfg_pkg::POS_PROC_EN];
    assign serialAudioOutEnable      = power_q[codec_cfg_pkg::POS_OUT_EN];
    assign serialAudioInEnable       = power_q[codec_cfg_pkg::POS_IN_EN];

    // ------------------------------------------------------------
    // Clock fields
    // ------------------------------------------------------------
    assign rateDivider      = clock_q[codec_cfg_pkg::POS_DIVIDER +: 2];
    assign systemSampleRate = clock_q[codec_cfg_pkg::POS_SYSRATE +: 2];
    assign masterClockRatio = clock_q[codec_cfg_pkg::POS_RATIO +: 2];
    assign pllClockSelect   = (masterClockRatio == codec_cfg_pkg::RATIO_PLL);
    assign serialFormat     = format_q;

    // ------------------------------------------------------------
    // Rate arithmetic
    // ------------------------------------------------------------
    wire [16:0]   sysRateHz;
    wire [2:0]    divisor;
    wire [9:0]    multiplier;

    // System rate in Hz from its code
    assign sysRateHz = (systemSampleRate == 2'h0) ? codec_cfg_pkg::HZ_32K :
                       (systemSampleRate == 2'h1) ? codec_cfg_pkg::HZ_44K1 :
                       (systemSampleRate == 2'h2) ? codec_cfg_pkg::HZ_48K :
                                                    codec_cfg_pkg::HZ_96K;

    // Divider code to divisor
    assign divisor = (rateDivider == 2'h0) ? codec_cfg_pkg::DIV_1 :
                     (rateDivider == 2'h1) ? codec_cfg_pkg::DIV_2 :
                     (rateDivider == 2'h2) ? codec_cfg_pkg::DIV_4 :
                                             codec_cfg_pkg::DIV_6;

    // Ratio code to multiplier, PLL gives no fixed ratio
    assign multiplier = (masterClockRatio == 2'h0) ? codec_cfg_pkg::MUL_256 :
                        (masterClockRatio == 2'h1) ? codec_cfg_pkg::MUL_384 :
                        (masterClockRatio == 2'h2) ? codec_cfg_pkg::MUL_512 :
                                                     10'h000;

    // Working rate is the divided system rate
    assign workingRate_d = sysRateHz / {14'h0000, divisor};

    // Expected master clock uses the undivided rate
    assign mclkHz_d = {10'h000, sysRateHz} * {17'h0_0000, multiplier};

    // Registered rate figures
    always_ff @(posedge clk) begin
        if (rst) begin
            workingRate_q <= 17'h0_0000;
            mclkHz_q      <= 27'h000_0000;
        end else begin
            workingRate_q <= workingRate_d;
            mclkHz_q      <= mclkHz_d;
        end
    end

    assign workingRateHz = workingRate_q;
    assign masterClockHz = mclkHz_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Read of a register and its answer one cycle later
    sequence s_readIdentity;
        readStrobe && hitIdentity;
    endsequence

    sequence s_readPower;
        readStrobe && hitPower;
    endsequence

    // Clock fields held for two edges, reset edge excluded
    sequence s_clockSteady;
        !rst && !writeClock ##1 !writeClock;
    endsequence

    a_identity_word:
    assert property (s_readIdentity |=> readData == {PART_ID, REVISION})
        else $error("identity word read wrong");

    a_adc_enable_write:
    assert property (writePower |=> adcPowerEnable == $past(writeData[6]))
        else $error("adc enable does not follow write");

    a_dac_enable_write:
    assert property (writePower ##1 !writePower |=> dacPowerEnable == $past(writeData[5], 2))
        else $error("dac enable does not hold written value");

    a_proc_enable_read:
    assert property (s_readPower |=> readData[4] == audioProcessorPowerEnable)
        else $error("processor enable readback wrong");

    a_out_enable_write:
    assert property (writePower && writeData[1] |=> serialAudioOutEnable)
        else $error("serial out enable not set");

    a_in_enable_hold:
    assert property (!rst && !writePower |=> $stable(serialAudioInEnable))
        else $error("serial in enable changed without write");

    a_power_reset_off:
    assert property ($fell(rst) |-> !adcPowerEnable && !dacPowerEnable
                     && !audioProcessorPowerEnable && !serialAudioOutEnable
                     && !serialAudioInEnable)
        else $error("power enables not cleared by reset");

    a_rate_half:
    assert property (s_clockSteady ##0 rateDivider == 2'h1 |-> workingRateHz * 2 == sysRateHz)
        else $error("half rate wrong");

    a_rate_sixth:
    assert property (s_clockSteady ##0 rateDivider == 2'h3 && systemSampleRate == 2'h3
                     |-> workingRateHz == 17'h0_3E80)
        else $error("sixth of 96 kHz wrong");

    a_mclk_undivided:
    assert property (s_clockSteady ##0 masterClockRatio == 2'h0
                     |-> masterClockHz == {sysRateHz, 8'h00} + 27'h000_0000)
        else $error("master clock not on undivided rate");

    a_sysrate_reset:
    assert property ($fell(rst) |-> systemSampleRate == 2'h2 && workingRateHz == 17'h0_0000)
        else $error("system rate reset code wrong");

    a_pll_select:
    assert property (writeClock && writeData[1:0] == 2'h3 |=> pllClockSelect ##1 masterClockHz == 27'h000_0000)
        else $error("pll selection not taken");

    a_reserved_zero:
    assert property (s_readPower |=> readData[15:7] == 9'h000 && readData[3:2] == $past(power_q[3:2]))
        else $error("power reserved bits read wrong");

    a_unmapped_zero:
    assert property (readStrobe && regAddr > 8'h06 |=> readData == 16'h0000)
        else $error("unmapped read not zero");

    a_idle_data_zero:
    assert property (!readStrobe |=> readData == 16'h0000)
        else $error("read data stands too long");

    // Stored fields move only on a write to their own offset
    a_power_hold:
    assert property (!rst && !writePower |=> $stable(power_q))
        else $error("power word changed without write");

    a_clock_hold:
    assert property (!rst && !writeClock |=> $stable(clock_q))
        else $error("clock word changed without write");

    a_format_hold:
    assert property (!rst && !writeFormat |=> $stable(format_q))
        else $error("format word changed without write");

    // Remaining enables follow a written zero or one
    a_dac_enable_clear:
    assert property (writePower && !writeData[5] |=> !dacPowerEnable)
        else $error("dac enable not cleared");

    a_proc_enable_write:
    assert property (writePower |=> audioProcessorPowerEnable == $past(writeData[4]))
        else $error("processor enable does not follow write");

    a_out_enable_clear:
    assert property (writePower && !writeData[1] |=> !serialAudioOutEnable)
        else $error("serial out enable not cleared");

    a_in_enable_write:
    assert property (writePower |=> serialAudioInEnable == $past(writeData[0]))
        else $error("serial in enable does not follow write");

    // Rate figures against the settled clock fields
    a_rate_full:
    assert property (s_clockSteady ##0 rateDivider == 2'h0 |-> workingRateHz == sysRateHz)
        else $error("undivided rate wrong");

    a_rate_quarter:
    assert property (s_clockSteady ##0 rateDivider == 2'h2 |-> workingRateHz * 4 == sysRateHz)
        else $error("quarter rate wrong");

    a_rate_44k1:
    assert property (s_clockSteady ##0 rateDivider == 2'h0 && systemSampleRate == 2'h1
                     |-> workingRateHz == 17'h0_AC44)
        else $error("44.1 kHz code gives wrong rate");

    a_mclk_ratio_384:
    assert property (s_clockSteady ##0 masterClockRatio == 2'h1
                     |-> masterClockHz == sysRateHz * 32'h0000_0180)
        else $error("384 ratio not on undivided rate");

    a_mclk_ratio_512:
    assert property (s_clockSteady ##0 masterClockRatio == 2'h2
                     |-> masterClockHz == sysRateHz * 32'h0000_0200)
        else $error("512 ratio not on undivided rate");

    a_pll_no_ratio:
    assert property (s_clockSteady ##0 pllClockSelect |-> masterClockHz == 27'h000_0000)
        else $error("pll clocking still shows a fixed ratio");

    a_clock_readback:
    assert property (readStrobe && hitClock |=> readData == {10'h000, $past(clock_q)})
        else $error("clock word readback wrong");

endmodule // codec_power_clock_config

`default_nettype wire

// [test/cfg_host_model.sv]
// Host processor model that programs the codec register port
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model #(
    parameter logic [7:0]  PLL_POWER_OFF  = 8'h30,    // Analog power word, outside this bank
    parameter logic [7:0]  PLL_DIV_OFF    = 8'h32,    // PLL divisor word, outside this bank
    parameter logic [15:0] PLL_POWER_WORD = 16'h0600, // PLL and oscillator amp power on
    parameter logic [15:0] PLL_DIV_WORD   = 16'h0000  // Divisors from master clock rate
) (
    input  wire logic        clk,
    input  wire logic [15:0] readData,
    output logic      [7:0]  regAddr,
    output logic      [15:0] writeData,
    output logic             writeStrobe,
    output logic             readStrobe
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    initial begin
        regAddr     = 8'h00;
        writeData   = 16'h0000;
        writeStrobe = 1'b0;
        readStrobe  = 1'b0;
    end

    // One-cycle write strobe
    task automatic busWrite(input logic [7:0] addr, input logic [15:0] data);
        @(posedge clk);
        regAddr     <= addr;
        writeData   <= data;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic busRead(input logic [7:0] addr, output logic [15:0] data);
        @(posedge clk);
        regAddr    <= addr;
        readStrobe <= 1'b1;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1 data = readData;
    endtask

    // Write then read back with no gap between strobes
    task automatic busWriteRead(input logic [7:0] addr, input logic [15:0] data,
                                output logic [15:0] rdata);
        @(posedge clk);
        regAddr     <= addr;
        writeData   <= data;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
        readStrobe  <= 1'b1;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1 rdata = readData;
    endtask

    // Switch to PLL clocking with the preparation done first
    task automatic pllSelect(input logic [5:0] clockWord);
        busWrite(PLL_POWER_OFF, PLL_POWER_WORD);
        busWrite(PLL_DIV_OFF, PLL_DIV_WORD);
        busWrite(codec_cfg_pkg::OFF_FORMAT, 16'h0090);
        busWrite(codec_cfg_pkg::OFF_CLOCK, {10'h000, clockWord[5:2], 2'h3});
    endtask
endmodule // cfg_host_model
`default_nettype wire

// [test/codec_power_clock_config_tb.sv]
// Self-checking bench for the codec power and clock register bank
`timescale 1ns/100ps
`default_nettype none
module codec_power_clock_config_tb;
    logic clk, rst, wStb, rStb, adcEn, dacEn, procEn, outEn, inEn, pllSel;
    logic [7:0]  addr;
    logic [15:0] wData, rData, rd;
    logic [1:0]  sysRate, rateDiv, ratio;
    logic [8:0]  fmt;
    logic [16:0] workHz;
    logic [26:0] mclkHz;
    int errCount, compares, cycles;
    int rateTab [4];
    int divTab [4];
    int mulTab [4];

    codec_power_clock_config #(.PART_ID(8'h3B), .REVISION(8'h07)) uut ( // Arbitrary codes
        .clk(clk), .rst(rst), .regAddr(addr), .writeData(wData), .writeStrobe(wStb),
        .readStrobe(rStb), .readData(rData), .adcPowerEnable(adcEn), .dacPowerEnable(dacEn),
        .audioProcessorPowerEnable(procEn), .serialAudioOutEnable(outEn),
        .serialAudioInEnable(inEn), .systemSampleRate(sysRate), .rateDivider(rateDiv),
        .masterClockRatio(ratio), .pllClockSelect(pllSel), .serialFormat(fmt),
        .workingRateHz(workHz), .masterClockHz(mclkHz));
    cfg_host_model host (.clk(clk), .readData(rData), .regAddr(addr), .writeData(wData),
        .writeStrobe(wStb), .readStrobe(rStb));

    // ------------------------------------------------------------
    // Clock, timeout, checking
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 32'h0000_0FA0) begin
            errCount++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Compares %0d errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Default contents after any reset
    task automatic checkReset;
        logic [15:0] v;
        host.busRead(codec_cfg_pkg::OFF_IDENTITY, v);
        check(v, 16'h3B07);
        host.busRead(codec_cfg_pkg::OFF_POWER, v);
        check(v, 16'h0000);
        host.busRead(codec_cfg_pkg::OFF_CLOCK, v);
        check(v, 16'h0008);
        host.busRead(codec_cfg_pkg::OFF_FORMAT, v);
        check(v, 16'h0010);
        host.busRead(8'h08, v);
        check(v, 16'h0000);
        @(posedge clk);
        #1 check(rData, 16'h0000);
        check(workHz, rateTab[2]);
        check(mclkHz, rateTab[2] * mulTab[0]);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rateTab = '{int'(codec_cfg_pkg::HZ_32K), int'(codec_cfg_pkg::HZ_44K1),
                    int'(codec_cfg_pkg::HZ_48K), int'(codec_cfg_pkg::HZ_96K)};
        divTab = '{int'(codec_cfg_pkg::DIV_1), int'(codec_cfg_pkg::DIV_2),
                   int'(codec_cfg_pkg::DIV_4), int'(codec_cfg_pkg::DIV_6)};
        mulTab = '{int'(codec_cfg_pkg::MUL_256), int'(codec_cfg_pkg::MUL_384),
                   int'(codec_cfg_pkg::MUL_512), 0};
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        checkReset();
        // Identity ignores writes
        host.busWriteRead(codec_cfg_pkg::OFF_IDENTITY, 16'hFFFF, rd);
        check(rd, 16'h3B07);
        // Each power bit alone, reserved bits included
        for (int i = 0; i < 16; i++) begin
            host.busWriteRead(codec_cfg_pkg::OFF_POWER, 16'h0001 << i, rd);
            check(rd, (16'h0001 << i) & 16'h007F);
            check({adcEn, dacEn, procEn, 2'h0, outEn, inEn}, (16'h0001 << i) & 16'h0073);
        end
        // Every rate, divider and ratio code
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                for (int m = 0; m < 4; m++) begin
                    host.busWriteRead(codec_cfg_pkg::OFF_CLOCK,
                        {10'h3FF, d[1:0], s[1:0], m[1:0]}, rd);
                    check(rd, {10'h000, d[1:0], s[1:0], m[1:0]});
                    check({rateDiv, sysRate, ratio, pllSel}, {d[1:0], s[1:0], m[1:0], m == 3});
                    check(workHz, rateTab[s] / divTab[d]);
                    check(mclkHz, rateTab[s] * mulTab[m]);
                end
            end
        end
        // PLL preparation leaves power bits untouched
        host.busWrite(codec_cfg_pkg::OFF_POWER, 16'h0051);
        host.pllSelect(6'h24);
        host.busRead(codec_cfg_pkg::OFF_POWER, rd);
        check(rd, 16'h0051);
        check({pllSel, ratio, rateDiv, mclkHz}, {1'b1, 2'h3, 2'h2, 27'h0});
        check(fmt, 9'h090);
        host.busWriteRead(codec_cfg_pkg::OFF_FORMAT, 16'hFFFF, rd);
        check(rd, 16'h01FF);
        // Reset again in mid-run
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        checkReset();
        check({adcEn, procEn, inEn, pllSel, fmt}, 13'h0010);
        end_sim();
    end
endmodule // codec_power_clock_config_tb
`default_nettype wire
